// *** rtl/rate_limit_pkg.sv ***
// constants and carrier types of the line rate mask limiter
package rate_limit_pkg;

    localparam logic [11:0] ASYM_CTRL_ADDR = 12'h13f;
    localparam logic [11:0] CAP_LOW_ADDR = 12'h208;
    localparam logic [11:0] CAP_HIGH_ADDR = 12'h209;
    localparam logic [11:0] MASK_LOW_ADDR = 12'h382;
    localparam logic [11:0] MASK_HIGH_ADDR = 12'h383;
    localparam logic [11:0] RX_MAX_ADDR = 12'h604;
    localparam logic [11:0] TX_MAX_ADDR = 12'h605;

    localparam int NUM_RATES = 14;
    localparam int ASYM_BIT = 6;
    localparam int CAP_ASYM_BIT = 7;
    localparam logic [3:0] TOP_RATE = 4'hd;
    localparam logic [13:0] ALL_RATES = 14'h3fff;
    localparam logic [7:0] HIGH_BYTE_VALID = 8'h3f;

    localparam logic [7:0] ASYM_CTRL_RESET = 8'h00;
    localparam logic [13:0] MASK_RESET = 14'h3fff;
    localparam logic [7:0] MAX_RATE_RESET = 8'h0d;
    localparam logic [13:0] CAP_RESET = 14'h0000;

    typedef enum logic [1:0] {PH_HANDSHAKE, PH_RETRAIN, PH_RENEGOTIATE} phase_t;

    // remote capability as received in the last handshake phase
    typedef struct packed {
        logic [13:0] rates;
        logic asym;
    } cap_t;

    // rate indices: 0 is 2400 bps, each step adds 2400 bps
    typedef struct packed {
        phase_t phase;
        logic [3:0] tx_rate;
        logic [3:0] rx_rate;
        logic [3:0] remote_rx_req;
    } rate_req_t;

    typedef struct packed {
        phase_t phase;
        logic ok;
        logic [3:0] tx_rate;
        logic [3:0] rx_rate;
    } rate_grant_t;

endpackage : rate_limit_pkg

// *** rtl/line_rate_mask_limiter.sv ***
// rate mask registers and rate clipping for the data pump
`timescale 1ns/1ns
module line_rate_mask_limiter (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // remote capability capture
    input wire logic cap_load,
    input wire rate_limit_pkg::cap_t cap_in,
    // rate decision from the data pump
    input wire logic req_valid,
    input wire rate_limit_pkg::rate_req_t req,
    output logic grant_valid,
    output rate_limit_pkg::rate_grant_t grant,
    // mode level
    output logic asym_enable
);

    typedef enum logic {S_IDLE, S_GRANT} state_t;

    // rate index and whether any bit was set
    typedef struct packed {
        logic ok;
        logic [3:0] idx;
    } top_t;

    state_t state_q, state_d;
    logic [7:0] asym_ctrl_q, asym_ctrl_d;
    logic [13:0] mask_q, mask_d;
    logic [7:0] rx_max_q, rx_max_d;
    logic [7:0] tx_max_q, tx_max_d;
    logic [13:0] cap_q, cap_d;
    logic cap_asym_q, cap_asym_d;
    logic [7:0] rdata_q, rdata_d;
    rate_limit_pkg::rate_grant_t grant_q, grant_d;

    logic asym;
    logic [13:0] tx_allow;
    logic [13:0] rx_allow;
    logic [3:0] sym_prop;
    top_t tx_top;
    top_t rx_top;
    top_t sym_top;

    // bits 0..n set; indices above the top rate leave all rates open
    function automatic logic [13:0] upto(input logic [7:0] n);
        logic [13:0] m;
        m = '0;
        for (int i = 0; i < rate_limit_pkg::NUM_RATES; i++)
        begin
            if (8'(i) <= n)
            begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : upto

    function automatic top_t top_of(input logic [13:0] m);
        top_t t;
        t = '0;
        for (int i = 0; i < rate_limit_pkg::NUM_RATES; i++)
        begin
            if (m[i])
            begin
                t.ok = 1'b1;
                t.idx = 4'(i);
            end
        end
        return t;
    endfunction : top_of

    assign asym = asym_ctrl_q[rate_limit_pkg::ASYM_BIT];
    assign asym_enable = asym;

    always_comb
    begin
        tx_allow = mask_q & cap_q & upto(tx_max_q);
        rx_allow = mask_q & cap_q & upto(rx_max_q);
        // remote receiver may ask for less
        if (asym)
        begin
            tx_allow = tx_allow & upto({4'h0, req.remote_rx_req});
        end
        // clip at the proposal, never above it
        tx_top = top_of(tx_allow & upto({4'h0, req.tx_rate}));
        rx_top = top_of(rx_allow & upto({4'h0, req.rx_rate}));
        sym_prop = (req.tx_rate < req.rx_rate) ? req.tx_rate : req.rx_rate;
        // one common rate for both directions
        sym_top = top_of(tx_allow & rx_allow & upto({4'h0, sym_prop}));
    end

    // register writes and captures
    always_comb
    begin
        asym_ctrl_d = asym_ctrl_q;
        mask_d = mask_q;
        rx_max_d = rx_max_q;
        tx_max_d = tx_max_q;
        cap_d = cap_q;
        cap_asym_d = cap_asym_q;
        if (reg_wr)
        begin
            if (reg_addr == rate_limit_pkg::ASYM_CTRL_ADDR)
            begin
                asym_ctrl_d = reg_wdata;
            end
            else if (reg_addr == rate_limit_pkg::MASK_LOW_ADDR)
            begin
                mask_d[7:0] = reg_wdata;
            end
            // reserved bits 14 and 15 dropped
            else if (reg_addr == rate_limit_pkg::MASK_HIGH_ADDR)
            begin
                mask_d[13:8] = reg_wdata[5:0];
            end
            else if (reg_addr == rate_limit_pkg::RX_MAX_ADDR)
            begin
                rx_max_d = reg_wdata;
            end
            else if (reg_addr == rate_limit_pkg::TX_MAX_ADDR)
            begin
                tx_max_d = reg_wdata;
            end
        end
        // store the remote mask and its asymmetric flag
        if (cap_load)
        begin
            cap_d = cap_in.rates;
            cap_asym_d = cap_in.asym;
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_rd)
        begin
            if (reg_addr == rate_limit_pkg::ASYM_CTRL_ADDR)
            begin
                rdata_d = asym_ctrl_q;
            end
            else if (reg_addr == rate_limit_pkg::CAP_LOW_ADDR)
            begin
                rdata_d = cap_q[7:0];
            end
            else if (reg_addr == rate_limit_pkg::CAP_HIGH_ADDR)
            begin
                rdata_d = {cap_asym_q, 1'b0, cap_q[13:8]};
            end
            else if (reg_addr == rate_limit_pkg::MASK_LOW_ADDR)
            begin
                rdata_d = mask_q[7:0];
            end
            else if (reg_addr == rate_limit_pkg::MASK_HIGH_ADDR)
            begin
                rdata_d = {2'b00, mask_q[13:8]};
            end
            else if (reg_addr == rate_limit_pkg::RX_MAX_ADDR)
            begin
                rdata_d = rx_max_q;
            end
            else if (reg_addr == rate_limit_pkg::TX_MAX_ADDR)
            begin
                rdata_d = tx_max_q;
            end
        end
    end

    // grant sequencing
    always_comb
    begin
        state_d = S_IDLE;
        grant_d = grant_q;
        if (req_valid)
        begin
            state_d = S_GRANT;
            grant_d.phase = req.phase;
            if (asym)
            begin
                grant_d.ok = tx_top.ok && rx_top.ok;
                grant_d.tx_rate = tx_top.idx;
                grant_d.rx_rate = rx_top.idx;
            end
            else
            begin
                grant_d.ok = sym_top.ok;
                grant_d.tx_rate = sym_top.idx;
                grant_d.rx_rate = sym_top.idx;
            end
        end
        case (state_q)
            S_IDLE: ;
            S_GRANT: ;
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_q <= S_IDLE;
            asym_ctrl_q <= rate_limit_pkg::ASYM_CTRL_RESET;
            mask_q <= rate_limit_pkg::MASK_RESET;
            rx_max_q <= rate_limit_pkg::MAX_RATE_RESET;
            tx_max_q <= rate_limit_pkg::MAX_RATE_RESET;
            cap_q <= rate_limit_pkg::CAP_RESET;
            cap_asym_q <= 1'b0;
            rdata_q <= 8'h00;
            grant_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            asym_ctrl_q <= asym_ctrl_d;
            mask_q <= mask_d;
            rx_max_q <= rx_max_d;
            tx_max_q <= tx_max_d;
            cap_q <= cap_d;
            cap_asym_q <= cap_asym_d;
            rdata_q <= rdata_d;
            grant_q <= grant_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign grant_valid = (state_q == S_GRANT);
    assign grant = grant_q;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_req;
        req_valid;
    endsequence

    sequence s_granted;
        ##1 grant_valid;
    endsequence

    a_grant_timing: assert property (s_req |-> s_granted)
        else $error("grant not one cycle after request");

    a_no_spurious: assert property (grant_valid |-> $past(req_valid))
        else $error("grant without request");

    a_idle_rdata: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");

    a_tx_in_mask: assert property (grant_valid && grant.ok |->
        ($past(mask_q) & $past(cap_q) & (14'h0001 << grant.tx_rate)) != 14'h0000
        && ($past(mask_q) & $past(cap_q) & (14'h0001 << grant.rx_rate)) != 14'h0000)
        else $error("granted rate disabled by mask");

    a_tx_no_raise: assert property (req_valid ##1 grant.ok |->
        grant.tx_rate <= $past(req.tx_rate)
        && grant.rx_rate <= $past(req.rx_rate))
        else $error("granted rate above proposal");

    a_sym_equal: assert property (grant_valid && !$past(asym) |->
        grant.tx_rate == grant.rx_rate)
        else $error("symmetric rates differ");

    a_max_caps: assert property (grant_valid && grant.ok |->
        {4'h0, grant.tx_rate} <= $past(tx_max_q)
        && {4'h0, grant.rx_rate} <= $past(rx_max_q))
        else $error("granted rate above maximum");

    a_remote_req: assert property (req_valid && asym ##1 grant.ok |->
        grant.tx_rate <= $past(req.remote_rx_req))
        else $error("transmit above remote request");

    a_reserved_zero: assert property (reg_rd
        && reg_addr == rate_limit_pkg::MASK_HIGH_ADDR |=>
        reg_rdata[7:6] == 2'b00 && mask_q[13:8] == reg_rdata[5:0])
        else $error("reserved mask bits not zero");

    a_cap_flag: assert property (cap_load ##1 reg_rd
        && reg_addr == rate_limit_pkg::CAP_HIGH_ADDR && !cap_load |=>
        reg_rdata[7] == $past(cap_in.asym, 2))
        else $error("remote asymmetric flag wrong");

    a_cap_store: assert property (cap_load |=>
        cap_q == $past(cap_in.rates))
        else $error("remote capability not stored");

endmodule : line_rate_mask_limiter

// *** testbench/remote_modem_model.sv ***
// remote modem model: hands its rate capability to the device
`timescale 1ns/1ns
module remote_modem_model (
    // clock
    input wire logic clock,
    // capability toward the device
    output logic cap_load,
    output rate_limit_pkg::cap_t cap_in
);
    initial
    begin
        cap_load = 1'b0;
        cap_in = '0;
    end
    task automatic send_cap(input logic [13:0] rates, input logic asym);
        @(posedge clock);
        cap_load <= 1'b1;
        cap_in <= '{rates: rates, asym: asym};
        @(posedge clock);
        cap_load <= 1'b0;
        cap_in <= ~cap_in;
    endtask : send_cap
endmodule : remote_modem_model

// *** testbench/test_line_rate_mask_limiter.sv ***
// self-checking bench of the line rate mask limiter
`timescale 1ns/1ns
module test_line_rate_mask_limiter;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic cap_load;
    rate_limit_pkg::cap_t cap_in;
    logic req_valid = 1'b0;
    rate_limit_pkg::rate_req_t req = '0;
    logic grant_valid;
    rate_limit_pkg::rate_grant_t grant;
    logic asym_enable;
    logic [7:0] rd_exp[$];
    rate_limit_pkg::rate_grant_t gr_exp[$];
    rate_limit_pkg::rate_grant_t eg;
    logic rd_pend = 1'b0;
    logic gv_pend = 1'b0;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    logic [15:0] rnd = 16'hbda6;
    logic [13:0] mask, cap;
    logic [7:0] ctrl, txmax, rxmax;
    logic casym;

    always #2 clock = ~clock;

    line_rate_mask_limiter u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cap_load(cap_load), .cap_in(cap_in), .req_valid(req_valid), .req(req),
        .grant_valid(grant_valid), .grant(grant), .asym_enable(asym_enable));
    remote_modem_model u_remote (.clock(clock), .cap_load(cap_load), .cap_in(cap_in));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [7:0] exp_reg(input logic [11:0] a);
        case (a)
            12'h13f: return ctrl;
            12'h208: return cap[7:0];
            12'h209: return {casym, 1'b0, cap[13:8]};
            12'h382: return mask[7:0];
            12'h383: return {2'h0, mask[13:8]};
            12'h604: return rxmax;
            12'h605: return txmax;
            default: return 8'h00;
        endcase
    endfunction : exp_reg

    function automatic logic [4:0] top(input logic [13:0] al, input logic [3:0] lim);
        logic [4:0] r;
        r = '0;
        for (int i = 0; i < 14; i++)
            if (al[i] && i <= lim) r = {1'b1, 4'(i)};
        return r;
    endfunction : top

    function automatic rate_limit_pkg::rate_grant_t calc(input rate_limit_pkg::rate_req_t q);
        logic [13:0] ta;
        logic [13:0] ra;
        logic [4:0] t;
        logic [4:0] v;
        ta = mask & cap;
        ra = mask & cap;
        for (int i = 0; i < 14; i++)
        begin
            if (txmax < 8'h0e && i > txmax) ta[i] = 1'b0;
            if (rxmax < 8'h0e && i > rxmax) ra[i] = 1'b0;
            if (ctrl[6] && i > q.remote_rx_req) ta[i] = 1'b0;
        end
        t = top(ta & ra, (q.tx_rate < q.rx_rate) ? q.tx_rate : q.rx_rate);
        v = t;
        if (ctrl[6])
        begin
            t = top(ta, q.tx_rate);
            v = top(ra, q.rx_rate);
        end
        return '{phase: q.phase, ok: t[4] & v[4], tx_rate: t[3:0], rx_rate: v[3:0]};
    endfunction : calc

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task automatic shadow_reset();
        mask = rate_limit_pkg::MASK_RESET;
        cap = rate_limit_pkg::CAP_RESET;
        ctrl = rate_limit_pkg::ASYM_CTRL_RESET;
        txmax = rate_limit_pkg::MAX_RATE_RESET;
        rxmax = rate_limit_pkg::MAX_RATE_RESET;
        casym = 1'b0;
    endtask : shadow_reset

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        case (a)
            12'h13f: ctrl = d;
            12'h382: mask[7:0] = d;
            12'h383: mask[13:8] = d[5:0];
            12'h604: rxmax = d;
            12'h605: txmax = d;
            default: ;
        endcase
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        rd_exp.push_back(exp_reg(a));
    endtask : rd

    task automatic check_all();
        logic [11:0] al[8] = '{12'h13f, 12'h208, 12'h209, 12'h382, 12'h383, 12'h604,
            12'h605, 12'h100};
        foreach (al[i]) rd(al[i]);
    endtask : check_all

    task automatic load_cap(input logic [13:0] rates, input logic asym);
        u_remote.send_cap(rates, asym);
        cap = rates;
        casym = asym;
    endtask : load_cap

    task automatic ask(input logic [1:0] ph, input logic [3:0] t, input logic [3:0] r,
        input logic [3:0] m);
        rate_limit_pkg::rate_req_t q;
        q = '{phase: rate_limit_pkg::phase_t'(ph), tx_rate: t, rx_rate: r, remote_rx_req: m};
        @(posedge clock);
        req_valid <= 1'b1;
        req <= q;
        gr_exp.push_back(calc(q));
        @(posedge clock);
        req_valid <= 1'b0;
        req <= ~q;
    endtask : ask

    always @(posedge clock)
    begin
        rd_pend <= reg_rd;
        gv_pend <= req_valid;
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            bad_count++;
            $display("BAD %0t timeout", $time);
            final_report();
        end
    end

    always @(negedge clock)
    begin
        if (rd_pend)
            chk(reg_rdata === rd_exp.pop_front(), "read data");
        else if (!rst)
            chk(reg_rdata === 8'h00, "idle read data");
        if (!rst)
            chk(grant_valid === gv_pend, "grant timing");
        if (grant_valid === 1'b1)
        begin
            eg = gr_exp.pop_front();
            chk(grant === eg, "grant");
        end
        if (!rst)
            chk(asym_enable === ctrl[6], "asym level");
    end

    initial
    begin
        shadow_reset();
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        check_all();
        wr(12'h383, 8'hff);
        wr(12'h208, 8'h5a);
        wr(12'h209, 8'hff);
        check_all();
        ask(2'h0, 4'hd, 4'hd, 4'hd);
        load_cap(14'h3fff, 1'b1);
        check_all();
        wr(12'h13f, 8'h40);
        fork
            load_cap(14'h0a5c, 1'b0);
            begin
                @(posedge clock);
                rd(12'h209);
            end
        join
        ask(2'h2, 4'hd, 4'hd, 4'h5);
        for (int n = 0; n < 80; n++)
        begin
            rnd = lfsr(rnd);
            case (rnd[2:0])
                3'h0: wr(12'h382, rnd[15:8]);
                3'h1: wr(12'h383, rnd[15:8]);
                3'h2: wr(12'h604, {4'h0, rnd[15:12]});
                3'h3: wr(12'h605, {4'h0, rnd[11:8]});
                3'h4: wr(12'h13f, rnd[15:8]);
                3'h5: load_cap(rnd[15:2], rnd[1]);
                default: check_all();
            endcase
            for (int k = 0; k < 3; k++)
            begin
                rnd = lfsr(rnd);
                ask(2'(rnd[15:14] % 3), 4'(rnd[3:0] % 14), 4'(rnd[7:4] % 14), 4'(rnd[11:8] % 14));
            end
        end
        @(posedge clock);
        rst <= 1'b1;
        shadow_reset();
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        check_all();
        ask(2'h1, 4'hd, 4'hd, 4'hd);
        repeat (3) @(posedge clock);
        chk(rd_exp.size() == 0 && gr_exp.size() == 0, "missing answers");
        final_report();
    end
endmodule : test_line_rate_mask_limiter
